// file: hw/rff_rate_alarm.sv
// Purpose: rate smoothing with jump-out, clip-off and low-flow alarm
// Assumes: rate samples come from same-clock logic with a valid strobe
// Notes: settings are plain ports and are sampled every cycle
`timescale 1ns/1ps
module rff_rate_alarm #(
  parameter int unsigned W = 24,
  parameter int unsigned TICK_DIV = rff_pkg::TICK_CYC
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic sample_vld_i,
  input wire logic [W-1:0] sample_i,
  input wire logic [3:0] smooth_i,
  input wire logic [3:0] step_sel_i,
  input wire logic [W-1:0] cutoff_i,
  input wire logic [W-1:0] low_flow_i,
  input wire logic alarm_en_i,
  input wire logic [2:0] alarm_out_sel_i,
  input wire logic inhibit_en_i,
  input wire logic [11:0] inhibit_s_i,
  input wire logic batch_run_i,
  input wire logic batch_start_i,
  output logic [W-1:0] rate_o,
  output logic rate_vld_o,
  output logic total_en_o,
  output logic [5:0] sw_out_o,
  output logic pause_o,
  output logic low_flow_o
);
  typedef struct packed {
    logic [W+5:0] acc;
    logic [W-1:0] rate;
    logic vld;
    logic tot;
    logic [5:0] sw;
    logic pause;
    logic low;
    logic [11:0] inh;
  } rff_st_t;
  rff_st_t st_ff, nxt_st;
  logic tick;
  logic [W-1:0] filt;
  logic [W-1:0] dev;
  logic [W+7:0] lim;
  logic jump;
  logic alarm;
  logic inh_act;
  logic [3:0] sh;

  // limit a setting to its table range
  function automatic logic [3:0] clamp9(input logic [3:0] v);
    clamp9 = (v > rff_pkg::SMOOTH_MAX) ? rff_pkg::SMOOTH_MAX : v;
  endfunction : clamp9

  rff_tick #(.DIV(TICK_DIV)) u_tick (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .restart_i(batch_start_i),
    .tick_o(tick)
  );

  // ==========================================================
  // filter arithmetic
  // accumulator keeps six fraction bits so long constants still creep to target
  always_comb begin
    sh = rff_pkg::SH_TAB[clamp9(smooth_i)];
    filt = st_ff.acc[W+5:6];
    dev = (sample_i > filt) ? (sample_i - filt) : (filt - sample_i);
    lim = ({8'h00, filt} * {{(W){1'b0}}, rff_pkg::STEP_TAB[clamp9(step_sel_i)]})
          >> rff_pkg::FRAC_SH;
    jump = (clamp9(step_sel_i) != rff_pkg::STEP_OFF) && ({8'h00, dev} > lim);
  end

  // inhibit gates alarm
  // on the start edge the fresh period counts, not the count left from the last batch
  assign inh_act = inhibit_en_i && (batch_start_i ? (inhibit_s_i != 12'h000)
                                                 : (st_ff.inh != 12'h000));
  // low-flow compare
  // only a strobed sample is a rate; the sample bus carries junk between strobes
  assign alarm = sample_vld_i && alarm_en_i && batch_run_i && (sample_i < low_flow_i) &&
                 !inh_act;

  // ==========================================================
  // next state
  always_comb begin
    nxt_st = st_ff;
    nxt_st.vld = 1'b0;
    if (sample_vld_i) begin
      if (sh == 4'h0 || jump) begin
        nxt_st.acc = {sample_i, 6'h00};
      end else begin
        nxt_st.acc = st_ff.acc - (st_ff.acc >> sh) + ({sample_i, 6'h00} >> sh);
      end
      nxt_st.rate = (sample_i < cutoff_i) ? '0 : nxt_st.acc[W+5:6];
      nxt_st.tot = (sample_i >= cutoff_i);
      nxt_st.vld = 1'b1;
    end
    // inhibit countdown, loaded at batch start, clamped to legal range
    if (batch_start_i) begin
      nxt_st.inh = (inhibit_s_i > rff_pkg::INHIBIT_MAX_S) ? rff_pkg::INHIBIT_MAX_S
                   : inhibit_s_i;
    end else if (tick && st_ff.inh != 12'h000) begin
      nxt_st.inh = st_ff.inh - 12'h001;
    end
    // alarm latches pause until the batch is stopped or restarted
    // set wins over a restart in the same cycle so a low sample is never lost
    if (alarm) begin
      nxt_st.pause = 1'b1;
      nxt_st.low = 1'b1;
    end else if (!batch_run_i || batch_start_i) begin
      nxt_st.pause = 1'b0;
      nxt_st.low = 1'b0;
    end
    for (int i = 0; i < int'(rff_pkg::NUM_OUT); i++) begin
      nxt_st.sw[i] = nxt_st.low && (alarm_out_sel_i == 3'(i));
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rate_o = st_ff.rate;
  assign rate_vld_o = st_ff.vld;
  assign total_en_o = st_ff.tot;
  assign sw_out_o = st_ff.sw;
  assign pause_o = st_ff.pause;
  assign low_flow_o = st_ff.low;

  // ==========================================================
  // checks
  // clip-off zero
  property p_clip;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      sample_vld_i && sample_i < cutoff_i |=> rate_o == '0 && !total_en_o;
  endproperty
  a_clip: assert property (p_clip) else $error("clip-off not applied");
  property p_bypass;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      sample_vld_i && jump && sample_i >= cutoff_i |=> rate_o == $past(sample_i);
  endproperty
  a_bypass: assert property (p_bypass) else $error("jump did not load sample");
  property p_nojump;
    @(posedge ref_clk_i) disable iff (!nrst_i) step_sel_i == 4'h0 |-> !jump;
  endproperty
  a_nojump: assert property (p_nojump) else $error("jump while disabled");
  property p_alarm;
    @(posedge ref_clk_i) disable iff (!nrst_i) alarm |=> pause_o && low_flow_o;
  endproperty
  a_alarm: assert property (p_alarm) else $error("low flow not paused");
  property p_onehot;
    @(posedge ref_clk_i) disable iff (!nrst_i) $onehot0(sw_out_o);
  endproperty
  a_onehot: assert property (p_onehot) else $error("more than one output");
  property p_inhibit;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      batch_start_i && inhibit_en_i && inhibit_s_i != 12'h000
      |=> !low_flow_o ##1 (!$past(inhibit_en_i) || !low_flow_o);
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("alarm during inhibit");
  property p_nofilt;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      sample_vld_i && smooth_i == 4'h0 && sample_i >= cutoff_i
      |=> rate_o == $past(sample_i);
  endproperty
  a_nofilt: assert property (p_nofilt) else $error("smoothing zero filtered");
  property p_vld;
    @(posedge ref_clk_i) disable iff (!nrst_i) sample_vld_i |=> rate_vld_o;
  endproperty
  a_vld: assert property (p_vld) else $error("no update per sample");

  // ==========================================================
  // latch and output checks
  // pause holds
  property p_hold_pause;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      pause_o && batch_run_i && !batch_start_i |=> pause_o;
  endproperty
  a_hold_pause: assert property (p_hold_pause) else $error("pause dropped");
  property p_stop_clear;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      !batch_run_i |=> !pause_o && !low_flow_o && sw_out_o == 6'h00;
  endproperty
  a_stop_clear: assert property (p_stop_clear) else $error("alarm kept after stop");
  property p_need_en;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      !alarm_en_i && !low_flow_o |=> !low_flow_o;
  endproperty
  a_need_en: assert property (p_need_en) else $error("alarm while disabled");
  property p_sw_idle;
    @(posedge ref_clk_i) disable iff (!nrst_i) !low_flow_o |-> sw_out_o == 6'h00;
  endproperty
  a_sw_idle: assert property (p_sw_idle) else $error("output closed without alarm");
  property p_sw_sel;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      alarm && alarm_out_sel_i < rff_pkg::NUM_OUT |=> sw_out_o[$past(alarm_out_sel_i)];
  endproperty
  a_sw_sel: assert property (p_sw_sel) else $error("assigned output not closed");
  property p_tot;
    @(posedge ref_clk_i) disable iff (!nrst_i) rate_o != '0 |-> total_en_o;
  endproperty
  a_tot: assert property (p_tot) else $error("rate shown but total stopped");
  property p_keep;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      !sample_vld_i |=> $stable(rate_o) && $stable(total_en_o) && !rate_vld_o;
  endproperty
  a_keep: assert property (p_keep) else $error("rate moved without sample");
endmodule : rff_rate_alarm

// file: hw/rff_tick.sv
// Purpose: one-second enable pulse divider
// Assumes: single reference clock
// Notes: restart re-aligns the divider with batch start
`timescale 1ns/1ps
module rff_tick #(
  parameter int unsigned DIV = rff_pkg::TICK_CYC
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic restart_i,
  output logic tick_o
);
  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } rff_tick_st_t;
  rff_tick_st_t st_ff, nxt_st;
  // ==========================================================
  // divider
  always_comb begin
    nxt_st = st_ff;
    nxt_st.tick = 1'b0;
    if (restart_i) begin
      nxt_st.cnt = '0;
    end else if (st_ff.cnt == 32'(DIV - 1)) begin
      nxt_st.cnt = '0;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.cnt = st_ff.cnt + 32'h1;
    end
  end
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign tick_o = st_ff.tick;
endmodule : rff_tick

// file: inc/rff_pkg.sv
// Purpose: constants for the rate filter and low-flow alarm block
// Assumes: 10 MHz reference clock, unsigned rate samples
// Notes: smoothing and step tables below are indexed by settings 0 to 9
// ==========================================================
package rff_pkg;
  // ==========================================================
  // timing
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned TICK_S = 1;
  localparam int unsigned TICK_CYC = CLK_HZ * TICK_S;
  localparam logic [11:0] INHIBIT_MAX_S = 12'hE10;
  // ==========================================================
  // step thresholds in 1/128 units of the display (1,2,4,8,12,16,24,32,64 %)
  // entries approximate percent*128/100, rounded up so tiny noise never jumps
  localparam logic [3:0] STEP_OFF = 4'h0;
  localparam logic [3:0] SMOOTH_MAX = 4'h9;
  localparam int unsigned FRAC_SH = 7;
  // smoothing shift per setting; larger shift means longer time constant
  localparam logic [3:0] SH_TAB [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h3, 4'h4,
                                         4'h4, 4'h5, 4'h5, 4'h5};
  localparam logic [7:0] STEP_TAB [10] = '{8'h00, 8'h02, 8'h03, 8'h06, 8'h0B,
                                           8'h10, 8'h15, 8'h1F, 8'h29, 8'h52};
  localparam logic [2:0] NUM_OUT = 3'h6;
endpackage : rff_pkg

// file: testbench/rff_flow_model.sv
// Purpose: flowmeter stand-in that delivers one rate sample per request
// Assumes: bench raises req_i just after an edge; model drives 10 ns after the next
// Notes: data is inverted between samples so a stale value never looks valid
`timescale 1ns/1ps
module rff_flow_model (
  input wire logic ref_clk_i,
  input wire logic req_i,
  input wire logic [23:0] val_i,
  output logic vld_o,
  output logic [23:0] data_o
);
  logic r;
  logic [23:0] v;
  // ==========================================================
  // sample strobe; request is read on the edge, driven off it
  // one process owns both outputs so each has a single driver
  initial begin
    vld_o = 1'b0;
    data_o = 24'h000000;
    forever begin
      @(posedge ref_clk_i);
      r = req_i;
      v = val_i;
      #10;
      vld_o <= r;
      data_o <= r ? v : ~data_o;
    end
  end
endmodule : rff_flow_model

// file: testbench/testbench.sv
// Purpose: self-checking bench for rate smoothing, jump, clip-off and low-flow alarm
// Assumes: 100 ns clock; one-second tick shortened to 10 cycles
// Notes: expected values come from bench functions, never from design outputs
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0, nrst = 1'b0, req = 1'b0, a_en = 1'b0, i_en = 1'b0, run = 1'b0, bs = 1'b0;
  logic [23:0] val = 24'h000000, cut = 24'h000000, lowf = 24'h000000, s, smp, rate;
  logic [3:0] sm = 4'h0, st = 4'h0;
  logic [2:0] sel = 3'h0;
  logic [11:0] ihs = 12'h000;
  logic svld, rvld, ten, pau, lfl;
  logic [5:0] sw;
  int num_errors = 0, checks = 0;
  always #50 clk = ~clk;
  rff_flow_model u_fm (.ref_clk_i(clk), .req_i(req), .val_i(val), .vld_o(svld), .data_o(smp));
  rff_rate_alarm #(.TICK_DIV(10)) u_dut (.ref_clk_i(clk), .nrst_i(nrst), .sample_vld_i(svld),
    .sample_i(smp), .smooth_i(sm), .step_sel_i(st), .cutoff_i(cut), .low_flow_i(lowf),
    .alarm_en_i(a_en), .alarm_out_sel_i(sel), .inhibit_en_i(i_en), .inhibit_s_i(ihs),
    .batch_run_i(run), .batch_start_i(bs), .rate_o(rate), .rate_vld_o(rvld),
    .total_en_o(ten), .sw_out_o(sw), .pause_o(pau), .low_flow_o(lfl));
  // ==========================================================
  // shared tasks and expectations
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // bounded wait for the answer pulse, sampled 10 ns after each edge
  task automatic send(input logic [23:0] v);
    int n;
    val = v;
    req = 1'b1;
    @(posedge clk);
    #10 req = 1'b0;
    for (n = 0; n < 5 && rvld !== 1'b1; n++) begin
      @(posedge clk);
      #10;
    end
    chk(rvld, 1'b1);
  endtask : send
  task automatic start();
    @(posedge clk);
    #10 bs = 1'b1;
    @(posedge clk);
    #10 bs = 1'b0;
  endtask : start
  function automatic logic [23:0] exp_rate(input logic [23:0] x);
    return (x < cut) ? 24'h000000 : x;
  endfunction : exp_rate
  function automatic logic [5:0] exp_sw(input logic [2:0] k);
    return (k < 3'h6) ? (6'h01 << k) : 6'h00;
  endfunction : exp_sw
  // first filtered move from 1000 toward 2000 is 1/2^shift of the gap; above 9 acts as 9
  function automatic logic [23:0] exp_smooth(input logic [3:0] k);
    logic [3:0] c;
    c = (k > rff_pkg::SMOOTH_MAX) ? rff_pkg::SMOOTH_MAX : k;
    return 24'h0003E8 + (24'h0003E8 >> rff_pkg::SH_TAB[c]);
  endfunction : exp_smooth
  task automatic final_report();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report
  // watchdog: whole run needs well under 30000 cycles
  initial begin
    #3000000;
    num_errors++;
    final_report();
  end
  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(21833));
    repeat (8) @(posedge clk);
    #10 nrst = 1'b1;
    // unfiltered path; clip-off boundary hit on purpose in two of every three samples, at cut and one below
    for (int n = 0; n < 24; n++) begin
      cut = 24'($urandom);
      s = (n % 3 == 0) ? cut : (n % 3 == 1) ? cut - 24'h000001 : 24'($urandom);
      send(s);
      chk(rate, exp_rate(s));
      chk(ten, s >= cut);
    end
    // jump-out per setting; setting zero must keep filtering
    cut = 24'h000000;
    for (int k = 0; k < 10; k++) begin
      sm = 4'h0;
      send(24'h0003E8);
      sm = 4'h9;
      st = 4'(k);
      send(24'h0007D0);
      chk(rate === 24'h0007D0, k != 0);
      if (k == 0) chk(rate, exp_smooth(4'h9));
    end
    // 40 percent step stays under the widest threshold
    sm = 4'h0;
    send(24'h0003E8);
    sm = 4'h9;
    send(24'h000578);
    // 1000 plus 400/32, truncated
    chk(rate, 24'h0003F4);
    // smoothing sweep with jump off, clamped settings included
    st = 4'h0;
    for (int k = 1; k < 16; k++) begin
      sm = 4'h0;
      send(24'h0003E8);
      sm = 4'(k);
      send(24'h0007D0);
      chk(rate, exp_smooth(4'(k)));
    end
    // low-flow alarm on every output index, setpoint itself is not low
    sm = 4'h0;
    st = 4'h0;
    lowf = 24'h000064;
    a_en = 1'b1;
    run = 1'b1;
    for (int k = 0; k < 8; k++) begin
      sel = 3'(k);
      start();
      send(24'h000064);
      chk(pau, 1'b0);
      send(24'h000032);
      chk(sw, exp_sw(sel));
      chk({pau, lfl}, 2'h3);
    end
    // inhibit of 3 s: low flow ignored at once, honoured after 5 s
    i_en = 1'b1;
    ihs = 12'h003;
    start();
    send(24'h000032);
    chk(pau, 1'b0);
    repeat (50) @(posedge clk);
    #10;
    send(24'h000032);
    chk(pau, 1'b1);
    // zero period means no inhibit at all
    ihs = 12'h000;
    start();
    send(24'h000032);
    chk(pau, 1'b1);
    final_report();
  end
endmodule : testbench
